/* File: rtl/oafb_flag_bank.sv */
`timescale 1ns/1ps
// How it works
// R1: sixteen read-only 16-bit lane flag registers from the lane base, reset zero.
// R2: lanes populated per module, up to sixteen, index zero to count minus one; the code populates index zero to lane_count inclusive.
// R3: lane bits 15:12 bias flags, 11:8 transmit power flags, high alarm first.
// R4: lane bits 7:4 laser temperature, 3:0 receive power, same ordering.
// R5: lane flags read one when asserted; bias and transmit power are class c.
// R6: laser temperature and receive power lane flags are class b.
// R7: one read-only module flag register, reset zero, bits 15:12 read zero.
// R8: module bits 11:8 module temperature flags, class a.
// R9: module bits 7:4 supply voltage flags, class a.
// R10: module bits 3:0 optical amplifier bias flags, class b.
// R11: lane bias measurement code spans zero to 131.072 mA.
// R12: lane transmit power measurement spans zero to 6.5535 mW.
// R13: lane receive power measurement spans zero to 6.5535 mW.
// R14: lane laser temperature measurement is in degrees Celsius.
// R15: three module measurements: temperature, 3.3 V supply, amplifier bias.
// R16: module measurements refresh every 100 ms without host action.
// R17: every flag has a host mask bit; a set mask blocks the global alarm.
// R18: with mask clear, an asserted flag triggers the global alarm.
// R19: global alarm is OR of unmasked flags; status reads have no side effect.
module oafb_flag_bank
    import oafb_pkg::*;
#(
    parameter int REFRESH_CNT = REFRESH_CYCLES
)
(
    // clock and reset
    input  wire logic                       hclk,
    input  wire logic                       hresetn,
    // ahb-lite slave
    input  wire logic                       hsel,
    input  wire logic [31:0]                haddr,
    input  wire logic [1:0]                 htrans,
    input  wire logic                       hwrite,
    input  wire logic [2:0]                 hsize,
    input  wire logic [31:0]                hwdata,
    input  wire logic                       hready,
    output      logic [31:0]                hrdata,
    output      logic                       hreadyout,
    output      logic                       hresp,
    // comparator flags, asynchronous to hclk
    input  wire logic [NUM_LANES-1:0][15:0] lane_flags_in,
    input  wire logic [11:0]                mod_flags_in,
    input  wire logic [3:0]                 lane_count,
    // converter results, same clock
    input  wire oafb_lane_meas_t [NUM_LANES-1:0] lane_meas_in,
    input  wire oafb_mod_meas_t             mod_meas_in,
    // alarm outputs
    output      logic                       global_alarm_output,
    output      logic                       irq
);

    logic [NUM_LANES-1:0][15:0] lane_sync1;
    logic [NUM_LANES-1:0][15:0] lane_flags;
    logic [NUM_LANES-1:0][15:0] lane_mask;
    logic [NUM_LANES-1:0]       lane_hit;
    logic [3:0]                 lane_cnt_sync1;
    logic [3:0]                 lane_cnt;
    logic                       rd_wait;
    logic [11:0]                mod_sync1;
    logic [15:0]                mod_flags;
    logic [15:0]                mod_mask;
    oafb_mod_meas_t             mod_meas;
    logic [31:0]                refresh_cnt;
    logic                       refresh_tick;
    logic                       next_alarm;
    logic                       alarm_q;
    logic [1:0]                 irq_stat;
    logic [1:0]                 irq_mask;
    logic [1:0]                 irq_evt;
    logic                       dp_write;
    logic [17:0]                dp_addr;
    logic                       ap_valid;
    logic [31:0]                next_rdata;

    // two-flop synchronisers for the comparator levels
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            lane_sync1 <= '0;
            lane_flags <= '0;
            mod_sync1  <= '0;
            mod_flags  <= FLAG_RESET;
            lane_cnt_sync1 <= 4'h0;
            lane_cnt       <= 4'h0;
        end
        else
        begin
            lane_sync1 <= lane_flags_in;
            mod_sync1  <= mod_flags_in;
            // the strap comes from a pin, so it is synchronised like the flags
            lane_cnt_sync1 <= lane_count;
            lane_cnt       <= lane_cnt_sync1; // R2
            mod_flags  <= {4'h0, mod_sync1} & MOD_VALID_MASK; // R7 R8 R9 R10
            for (int i = 0; i < NUM_LANES; i++)
            begin
                // unpopulated lanes stay clear
                if (i[3:0] <= lane_cnt)
                    lane_flags[i] <= lane_sync1[i]; // R1 R2 R3 R4 R5 R6
                else
                    lane_flags[i] <= FLAG_RESET;
            end
        end
    end

    // periodic capture of module measurements
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            refresh_cnt <= '0;
            mod_meas    <= '0;
        end
        else
        begin
            if (refresh_tick)
                refresh_cnt <= '0;
            else
                refresh_cnt <= refresh_cnt + 32'h0000_0001;
            if (refresh_tick)
                mod_meas <= mod_meas_in; // R15 R16
        end
    end
    assign refresh_tick = (refresh_cnt == 32'(REFRESH_CNT - 1)); // R16

    // global alarm combine
    genvar g;
    generate
        for (g = 0; g < NUM_LANES; g++)
        begin : g_lane
            assign lane_hit[g] = |(lane_flags[g] & ~lane_mask[g]); // R17 R18
        end
    endgenerate
    assign next_alarm = (|lane_hit) | (|(mod_flags & ~mod_mask)); // R19

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            alarm_q <= 1'b0;
        else
            alarm_q <= next_alarm;
    end
    assign global_alarm_output = alarm_q;

    // interrupt events: alarm rise, measurement refresh
    assign irq_evt = {refresh_tick, next_alarm & ~alarm_q};

    // ahb-lite address phase capture
    assign ap_valid = hsel & hready & (htrans == HTRANS_NONSEQ);
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dp_write <= 1'b0;
            dp_addr  <= '0;
        end
        else
        begin
            dp_write <= ap_valid & hwrite;
            if (ap_valid)
                dp_addr <= haddr[17:0];
        end
    end

    // mask registers, reset all masked so nothing alarms before software is ready
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            lane_mask <= {NUM_LANES{MASK_RESET}};
            mod_mask  <= MASK_RESET;
            irq_mask  <= IRQ_MASK_RESET;
        end
        else if (dp_write)
        begin
            for (int i = 0; i < NUM_LANES; i++)
            begin
                if (dp_addr == ADDR_LANE_MASK + 18'(i * 4))
                    lane_mask[i] <= hwdata[15:0]; // R17
            end
            if (dp_addr == ADDR_MOD_MASK)
                mod_mask <= hwdata[15:0]; // R17
            if (dp_addr == ADDR_IRQ_MASK)
                irq_mask <= hwdata[1:0];
        end
    end

    // sticky interrupt status, set wins over write-one-to-clear
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            irq_stat <= 2'b00;
        else if (dp_write && dp_addr == ADDR_IRQ_STAT)
            irq_stat <= (irq_stat & ~hwdata[1:0]) | irq_evt;
        else
            irq_stat <= irq_stat | irq_evt;
    end
    assign irq = |(irq_stat & irq_mask);

    // read mux; status reads have no side effect
    always_comb
    begin
        next_rdata = 32'h0000_0000;
        if (dp_addr == ADDR_MOD_FLAGS)
            next_rdata = {16'h0000, mod_flags}; // R7 R19
        if (dp_addr == ADDR_MOD_MASK)
            next_rdata = {16'h0000, mod_mask};
        if (dp_addr == ADDR_MOD_MEAS)
            next_rdata = {16'h0000, mod_meas.mod_temp}; // R15
        if (dp_addr == ADDR_MOD_MEAS + 18'h0_0004)
            next_rdata = {16'h0000, mod_meas.supply_3v3}; // R15
        if (dp_addr == ADDR_MOD_MEAS + 18'h0_0008)
            next_rdata = {16'h0000, mod_meas.amp_bias}; // R15
        if (dp_addr == ADDR_IRQ_STAT)
            next_rdata = {30'h0000_0000, irq_stat};
        if (dp_addr == ADDR_IRQ_MASK)
            next_rdata = {30'h0000_0000, irq_mask};
        for (int i = 0; i < NUM_LANES; i++)
        begin
            if (dp_addr == ADDR_LANE_BASE + 18'(i * 4))
                next_rdata = {16'h0000, lane_flags[i]}; // R1
            if (dp_addr == ADDR_LANE_MASK + 18'(i * 4))
                next_rdata = {16'h0000, lane_mask[i]};
            // four words per lane: bias, tx power, laser temp, rx power codes
            if (dp_addr == ADDR_LANE_MEAS + 18'(i * 16))
                next_rdata = {16'h0000, lane_meas_in[i].bias}; // R11
            if (dp_addr == ADDR_LANE_MEAS + 18'(i * 16 + 4))
                next_rdata = {16'h0000, lane_meas_in[i].tx_power}; // R12
            if (dp_addr == ADDR_LANE_MEAS + 18'(i * 16 + 8))
                next_rdata = {16'h0000, lane_meas_in[i].laser_temp}; // R14
            if (dp_addr == ADDR_LANE_MEAS + 18'(i * 16 + 12))
                next_rdata = {16'h0000, lane_meas_in[i].rx_power}; // R13
        end
    end

    // reads take one wait state so that read data leaves a flip-flop;
    // writes stay zero-wait and land at the end of their data phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rd_wait <= 1'b0;
            hrdata  <= 32'h0000_0000;
        end
        else
        begin
            rd_wait <= ap_valid & ~hwrite;
            if (rd_wait)
                hrdata <= next_rdata; // R19
        end
    end
    assign hreadyout = ~rd_wait;
    assign hresp     = 1'b0;

endmodule

/* File: rtl/oafb_pkg.sv */
package oafb_pkg;

    // lane and module register layout
    localparam int          NUM_LANES        = 16;
    localparam logic [15:0] LANE_FLAG_BASE   = 16'hA200;
    localparam logic [15:0] MOD_FLAG_IDX     = 16'hA01F;
    localparam logic [15:0] FLAG_RESET       = 16'h0000;
    localparam int          BIAS_HI          = 15;
    localparam int          TXP_HI           = 11;
    localparam int          LTEMP_HI         = 7;
    localparam int          RXP_HI           = 3;
    localparam int          MTEMP_HI         = 11;
    localparam int          MVCC_HI          = 7;
    localparam int          MAMP_HI          = 3;
    localparam logic [15:0] MOD_VALID_MASK   = 16'h0FFF;

    // byte addresses are four times the printed index
    localparam logic [17:0] ADDR_MOD_FLAGS   = {MOD_FLAG_IDX, 2'b00};
    localparam logic [17:0] ADDR_LANE_BASE   = {LANE_FLAG_BASE, 2'b00};
    // own registers at chosen indices
    localparam logic [15:0] LANE_MASK_IDX    = 16'hB200;
    localparam logic [15:0] MOD_MASK_IDX     = 16'hB01F;
    localparam logic [15:0] LANE_MEAS_IDX    = 16'hB400;
    localparam logic [15:0] MOD_MEAS_IDX     = 16'hB500;
    localparam logic [15:0] IRQ_STAT_IDX     = 16'hB600;
    localparam logic [15:0] IRQ_MASK_IDX     = 16'hB601;
    localparam logic [17:0] ADDR_LANE_MASK   = {LANE_MASK_IDX, 2'b00};
    localparam logic [17:0] ADDR_MOD_MASK    = {MOD_MASK_IDX, 2'b00};
    localparam logic [17:0] ADDR_LANE_MEAS   = {LANE_MEAS_IDX, 2'b00};
    localparam logic [17:0] ADDR_MOD_MEAS    = {MOD_MEAS_IDX, 2'b00};
    localparam logic [17:0] ADDR_IRQ_STAT    = {IRQ_STAT_IDX, 2'b00};
    localparam logic [17:0] ADDR_IRQ_MASK    = {IRQ_MASK_IDX, 2'b00};
    localparam logic [15:0] MASK_RESET       = 16'hFFFF;
    localparam logic [1:0]  IRQ_MASK_RESET   = 2'b00;

    // measurement full scale
    localparam real         BIAS_FULL_MA     = 131.072;
    localparam real         OPT_FULL_MW      = 6.5535;

    // refresh period of module measurements
    localparam real         CLK_MHZ          = 40.0;
    localparam real         REFRESH_MS       = 100.0;
    localparam int          REFRESH_CYCLES   = int'(REFRESH_MS * 1000.0 * CLK_MHZ);

    localparam logic [1:0]  HTRANS_NONSEQ    = 2'b10;
    localparam logic [2:0]  HSIZE_WORD       = 3'b010;

    typedef struct packed {
        logic [15:0] bias;
        logic [15:0] tx_power;
        logic [15:0] laser_temp;
        logic [15:0] rx_power;
    } oafb_lane_meas_t;

    typedef struct packed {
        logic [15:0] mod_temp;
        logic [15:0] supply_3v3;
        logic [15:0] amp_bias;
    } oafb_mod_meas_t;

endpackage

/* File: test/oafb_flag_bank_properties.sv */
`timescale 1ns/1ps
module oafb_flag_bank_properties
    import oafb_pkg::*;
#(
    parameter int REFRESH_CNT = 20
)
(
    // clock and reset
    input wire logic                            hclk,
    input wire logic                            hresetn,
    // bus
    input wire logic                            hsel,
    input wire logic [31:0]                     haddr,
    input wire logic [1:0]                      htrans,
    input wire logic                            hwrite,
    input wire logic                            hready,
    input wire logic [31:0]                     hrdata,
    input wire logic                            hreadyout,
    input wire logic                            hresp,
    // flags, measurements, alarm
    input wire logic [NUM_LANES-1:0][15:0]      lane_flags_in,
    input wire logic [11:0]                     mod_flags_in,
    input wire oafb_lane_meas_t [NUM_LANES-1:0] lane_meas_in,
    input wire logic                            global_alarm_output
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic rd;
    assign rd = hsel && hready && htrans == HTRANS_NONSEQ && !hwrite;
    a_read_wait: assert property (rd |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    a_write_ready: assert property (hsel && hready && htrans == HTRANS_NONSEQ && hwrite |=> hreadyout)
        else $error("write stalled");
    a_resp_okay: assert property (!hresp)
        else $error("hresp not okay");
    // flags reach the alarm three edges late, so six quiet edges suffice
    a_alarm_quiet: assert property ((lane_flags_in == '0 && mod_flags_in == '0) [*6] |-> !global_alarm_output)
        else $error("alarm without flag");
    a_mod_reserved: assert property (rd && haddr[17:0] == ADDR_MOD_FLAGS |=> ##1 hrdata[31:12] == 20'h0_0000)
        else $error("module reserved bits set");
    a_mod_map: assert property ($stable(mod_flags_in) [*5] ##0 (rd && haddr[17:0] == ADDR_MOD_FLAGS)
        |=> ##1 hrdata == {20'h0_0000, $past(mod_flags_in, 2)})
        else $error("module flag mapping");
    a_lane_map: assert property ($stable(lane_flags_in[0]) [*5] ##0 (rd && haddr[17:0] == ADDR_LANE_BASE)
        |=> ##1 hrdata == {16'h0000, $past(lane_flags_in[0], 2)})
        else $error("lane flag mapping");
    a_meas_live: assert property (rd && haddr[17:0] == ADDR_LANE_MEAS
        |=> ##1 hrdata == {16'h0000, $past(lane_meas_in[0].bias)})
        else $error("lane bias value");
    a_unmapped_zero: assert property (rd && haddr[17:0] == 18'h0_0000 |=> ##1 hrdata == 32'h0000_0000)
        else $error("unmapped read not zero");
endmodule
bind oafb_flag_bank oafb_flag_bank_properties #(.REFRESH_CNT(REFRESH_CNT)) i_props (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp,
    .lane_flags_in, .mod_flags_in, .lane_meas_in, .global_alarm_output);

/* File: test/oafb_host_model.sv */
`timescale 1ns/1ps
module oafb_host_model
    import oafb_pkg::*;
(
    // bus inputs
    input  wire logic        hclk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    // master outputs
    output      logic        hsel,
    output      logic [31:0] haddr,
    output      logic [1:0]  htrans,
    output      logic        hwrite,
    output      logic [2:0]  hsize,
    output      logic [31:0] hwdata
);
    initial
    begin
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = HSIZE_WORD;
        hwdata = 32'h0000_0000;
    end
    // released lines show the inverse so stale values never pass
    task automatic xfer(input logic w, input logic [17:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {14'h0000, a};
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        haddr <= ~{14'h0000, a};
        htrans <= 2'b00;
        hwdata <= w ? d : ~d;
        do @(posedge hclk); while (hready !== 1'b1);
        q = hrdata;
        hwdata <= ~d;
    endtask
endmodule

/* File: test/optic_module_alarm_flag_bank_tb.sv */
`timescale 1ns/1ps
module optic_module_alarm_flag_bank_tb;
    import oafb_pkg::*;
    localparam int RCNT = 20;
    logic                            hclk = 1'b0;
    logic                            hresetn, hsel, hwrite, hreadyout, hresp, alarm, irq;
    wire                             hready = hreadyout;
    logic [1:0]                      htrans;
    logic [2:0]                      hsize;
    logic [31:0]                     haddr, hwdata, hrdata, q;
    logic [NUM_LANES-1:0][15:0]      lf;
    logic [11:0]                     mf;
    logic [3:0]                      lc;
    oafb_lane_meas_t [NUM_LANES-1:0] lm;
    oafb_mod_meas_t                  mm;
    int                              fail_count, samples_checked, cyc;
    always #12.5 hclk = ~hclk;
    oafb_flag_bank #(.REFRESH_CNT(RCNT)) i_oafb_flag_bank (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout,
        .hresp, .lane_flags_in(lf), .mod_flags_in(mf), .lane_count(lc), .lane_meas_in(lm),
        .mod_meas_in(mm), .global_alarm_output(alarm), .irq);
    oafb_host_model i_oafb_host_model (.hclk, .hready, .hrdata, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata);
    task automatic conclude();
        if (fail_count == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        samples_checked++;
        if (g !== x)
        begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, g, x);
        end
    endtask
    task automatic rd(input logic [17:0] a, input logic [31:0] x);
        i_oafb_host_model.xfer(1'b0, a, 32'h0000_0000, q);
        chk(q, x);
    endtask
    task automatic wr(input logic [17:0] a, input logic [31:0] d);
        i_oafb_host_model.xfer(1'b1, a, d, q);
    endtask
    // model: a lane shows only up to the highest populated index
    function automatic logic [31:0] lane_exp(input int i);
        return (i <= int'(lc)) ? {16'h0000, lf[i]} : 32'h0000_0000;
    endfunction
    always @(posedge hclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fail_count++;
            conclude();
        end
    end
    initial
    begin
        void'($urandom(32'hc7af));
        hresetn <= 1'b0;
        lf <= '0;
        mf <= '0;
        lc <= 4'hf;
        lm <= '0;
        mm <= '0;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        for (int i = 0; i < 16; i++)
        begin
            rd(ADDR_LANE_BASE + 18'(4 * i), 32'h0000_0000);
            rd(ADDR_LANE_MASK + 18'(4 * i), 32'h0000_ffff);
            lf[i] <= 16'($urandom);
            lm[i] <= {$urandom, $urandom};
        end
        rd(ADDR_MOD_FLAGS, 32'h0000_0000);
        rd(ADDR_MOD_MASK, 32'h0000_ffff);
        rd(18'h0_0000, 32'h0000_0000);
        mf <= 12'($urandom);
        mm <= 48'({$urandom, $urandom});
        lc <= 4'h5;
        wr(ADDR_LANE_BASE, 32'h0000_ffff);
        repeat (RCNT + 4) @(posedge hclk);
        for (int i = 0; i < 16; i++)
        begin
            rd(ADDR_LANE_BASE + 18'(4 * i), lane_exp(i));
            for (int k = 0; k < 4; k++)
                rd(ADDR_LANE_MEAS + 18'(16 * i + 4 * k), {16'h0000, lm[i][63 - 16 * k -: 16]});
        end
        rd(ADDR_MOD_FLAGS, {20'h0_0000, mf});
        rd(ADDR_MOD_MEAS, {16'h0000, mm.mod_temp});
        rd(ADDR_MOD_MEAS + 18'h0_0004, {16'h0000, mm.supply_3v3});
        rd(ADDR_MOD_MEAS + 18'h0_0008, {16'h0000, mm.amp_bias});
        chk({31'h0000_0000, alarm}, 32'h0000_0000);
        lf <= '0;
        mf <= '0;
        for (int i = 0; i < 16; i++)
            wr(ADDR_LANE_MASK + 18'(4 * i), 32'h0000_0000);
        wr(ADDR_MOD_MASK, 32'h0000_0000);
        rd(ADDR_MOD_MASK, 32'h0000_0000);
        wr(ADDR_IRQ_STAT, 32'h0000_0003);
        wr(ADDR_IRQ_MASK, 32'h0000_0001);
        chk({31'h0000_0000, alarm}, 32'h0000_0000);
        mf <= 12'h800;
        repeat (5) @(posedge hclk);
        #1;
        chk({30'h0000_0000, alarm, irq}, 32'h0000_0003);
        wr(ADDR_IRQ_STAT, 32'h0000_0001);
        #1;
        chk({31'h0000_0000, irq}, 32'h0000_0000);
        rd(ADDR_MOD_FLAGS, 32'h0000_0800);
        rd(ADDR_MOD_FLAGS, 32'h0000_0800);
        wr(ADDR_MOD_MASK, 32'h0000_0800);
        repeat (3) @(posedge hclk);
        #1;
        chk({31'h0000_0000, alarm}, 32'h0000_0000);
        lf[2] <= 16'h0001;
        repeat (5) @(posedge hclk);
        #1;
        chk({31'h0000_0000, alarm}, 32'h0000_0001);
        conclude();
    end
endmodule
